/* core/i2ces_cond_det.sv */
`timescale 1ns/1ns
`default_nettype none

module i2ces_cond_det (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // synchronised bus levels
    input  wire logic scl_s,
    input  wire logic sda_s,
    // detected conditions
    output logic      start_p,
    output logic      stop_p,
    output logic      scl_rise
);
    import i2ces_pkg::*;

    i2ces_det_reg_t q;
    i2ces_det_reg_t n;

    always_comb begin
        n       = q;
        n.scl_d = scl_s;
        n.sda_d = sda_s;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '{scl_d: 1'b1, sda_d: 1'b1};
        end else begin
            q <= n;
        end
    end

    // sda falls or rises while scl stays high
    assign start_p  = scl_s && q.scl_d && q.sda_d && !sda_s;
    assign stop_p   = scl_s && q.scl_d && !q.sda_d && sda_s;
    assign scl_rise = scl_s && !q.scl_d;

endmodule // i2ces_cond_det
`default_nettype wire

/* core/i2ces_core.sv */
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "i2ces_regs.svh"

module i2ces_core #(
    parameter int unsigned HALF_CYC = `I2CES_SCL_HALF_CYC,
    parameter logic [6:0]  OWN_ADDR = `I2CES_OWN_ADDR
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // two-wire bus, open drain
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // event outputs
    output logic             irq,
    output logic             bus_error_flag,
    output logic             master_done_no_stop_flag,
    output logic             arbitration_lost_flag
);
    import i2ces_pkg::*;

    localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);
    localparam i2ces_core_reg_t CORE_RST = '{mst: MS_IDLE, waitreq: 1'b1, default: '0};

    i2ces_core_reg_t q;
    i2ces_core_reg_t n;

    logic [1:0]  pins_s;
    logic        scl_s;
    logic        sda_s;
    logic        start_p;
    logic        stop_p;
    logic        scl_rise;
    logic        wr_go;
    logic        launch;
    logic        count_en;
    logic        tick;
    logic        tx_bit;
    logic        fin_ev;
    logic        arb_ev;
    logic        ebus_m;
    logic        ebus_ev;
    logic [7:0]  slv_byte;
    logic [31:0] bem;
    logic [31:0] set_v;
    logic [31:0] clr_v;

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [7:0] addr_byte(input logic [31:0] cmd);
        addr_byte = {cmd[6:0], cmd[`I2CES_CMD_RNW]};
    endfunction

    function automatic logic [7:0] slv_byte_shift(input logic [7:0] sh, input logic b);
        slv_byte_shift = {sh[6:0], b};
    endfunction

    // ----------------------------------------------------------------
    // pin synchroniser and condition detector
    // ----------------------------------------------------------------
    i2ces_sync u_sync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pin_async ({scl_in, sda_in}),
        .pin_sync  (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    i2ces_cond_det u_det (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .scl_s    (scl_s),
        .sda_s    (sda_s),
        .start_p  (start_p),
        .stop_p   (stop_p),
        .scl_rise (scl_rise)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n        = q;
        wr_go    = avs_write && !q.waitreq;
        bem      = be_mask(avs_byteenable);
        launch   = 1'b0;
        fin_ev   = 1'b0;
        arb_ev   = 1'b0;
        ebus_m   = 1'b0;
        ebus_ev  = 1'b0;
        set_v    = '0;
        clr_v    = '0;
        slv_byte = {q.slv_sh[6:0], sda_s};
        tx_bit   = (q.bitn != `I2CES_ACK_BIT) && (!q.byten || !q.cmd[`I2CES_CMD_RNW]);
        count_en = (q.mst == MS_START || q.mst == MS_BIT || q.mst == MS_STOP)
                   && (q.step != 2'd1 || scl_s);
        tick     = count_en && (q.cnt == HALF_LAST);
        n.cnt    = (count_en && !tick) ? q.cnt + 16'd1 : 16'd0;

        // bus slave: one wait cycle, then answer
        n.waitreq = 1'b1;
        if ((avs_read || avs_write) && q.waitreq) begin
            n.waitreq = 1'b0;
            n.rdata   = '0;
            if (avs_read) begin
                case (avs_address)
                    `I2CES_OFS_CMD:    n.rdata = q.cmd;
                    `I2CES_OFS_RESULT: n.rdata = {16'h0000, q.result};
                    `I2CES_OFS_MASK:   n.rdata = q.mask;
                    `I2CES_OFS_RAW:    n.rdata = q.raw & `I2CES_RAW_IMPL;
                    `I2CES_OFS_MSKD:   n.rdata = q.raw & q.mask;
                    default:           n.rdata = '0;
                endcase
            end
        end
        if (wr_go) begin
            case (avs_address)
                `I2CES_OFS_CMD: begin
                    // refused while busy or while the unstopped done is pending
                    if (q.mst == MS_IDLE && !q.raw[`I2CES_BIT_MDNS]) begin
                        n.cmd  = ((avs_writedata & bem) | (q.cmd & ~bem)) & `I2CES_CMD_IMPL;
                        launch = 1'b1;
                    end
                end
                `I2CES_OFS_MASK: begin
                    n.mask = ((avs_writedata & bem) | (q.mask & ~bem)) & `I2CES_RAW_IMPL;
                end
                `I2CES_OFS_CLR: begin
                    clr_v = avs_writedata & bem & `I2CES_RAW_IMPL;
                end
                default: begin
                end
            endcase
        end

        // ----------------------------------------------------------------
        // master engine
        // ----------------------------------------------------------------
        case (q.mst)
            MS_IDLE: begin
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                if (launch) begin
                    n.mst    = MS_START;
                    n.step   = 2'd0;
                    n.byten  = 1'b0;
                    n.sh     = addr_byte(n.cmd);
                    n.result = '0;
                end
            end
            MS_START: begin
                case (q.step)
                    2'd0: begin
                        n.sda_oe = 1'b0;
                        if (tick) n.step = 2'd1;
                    end
                    2'd1: begin
                        n.scl_oe = 1'b0;
                        if (tick) n.step = 2'd2;
                    end
                    default: begin
                        n.sda_oe = 1'b1;
                        if (tick) begin
                            n.mst  = MS_BIT;
                            n.step = 2'd0;
                            n.bitn = 4'h0;
                        end
                    end
                endcase
            end
            MS_BIT: begin
                if (q.step == 2'd0) begin
                    n.scl_oe = 1'b1;
                    n.sda_oe = tx_bit && !q.sh[7];
                    if (tick) n.step = 2'd1;
                end else begin
                    n.scl_oe = 1'b0;
                    if (tick) begin
                        n.step = 2'd0;
                        if (tx_bit && q.sh[7] && !sda_s) begin
                            arb_ev = 1'b1;
                        end else if (q.bitn != `I2CES_ACK_BIT) begin
                            n.sh   = slv_byte_shift(q.sh, sda_s);
                            n.bitn = q.bitn + 4'h1;
                        end else if ((!q.byten || !q.cmd[`I2CES_CMD_RNW]) && sda_s) begin
                            n.result[`I2CES_RES_ERROR_TAG_FIELD_MSB:0] = `I2CES_ERROR_TAG_FIELD_NACK;
                            fin_ev = 1'b1;
                        end else if (!q.byten) begin
                            n.byten = 1'b1;
                            n.bitn  = 4'h0;
                            n.sh    = q.cmd[`I2CES_CMD_RNW] ? 8'h00
                                      : q.cmd[`I2CES_CMD_WD_MSB:`I2CES_CMD_WD_LSB];
                        end else begin
                            if (q.cmd[`I2CES_CMD_RNW]) begin
                                n.result[`I2CES_RES_RX_MSB:`I2CES_RES_RX_LSB] = q.sh;
                            end
                            fin_ev = 1'b1;
                        end
                    end
                end
                if (start_p || stop_p) ebus_m = 1'b1;
            end
            MS_STOP: begin
                case (q.step)
                    2'd0: begin
                        n.scl_oe = 1'b1;
                        n.sda_oe = 1'b1;
                        if (tick) n.step = 2'd1;
                    end
                    2'd1: begin
                        n.scl_oe = 1'b0;
                        if (tick) n.step = 2'd2;
                    end
                    default: begin
                        n.sda_oe = 1'b0;
                        if (tick) begin
                            n.mst = MS_IDLE;
                            set_v[`I2CES_BIT_MTD] = 1'b1;
                        end
                    end
                endcase
            end
            MS_HOLD: begin
                // clock stretched, no stop, until software acknowledges
                n.scl_oe = 1'b1;
                n.sda_oe = 1'b0;
                if (!q.raw[`I2CES_BIT_MDNS]) begin
                    n.mst    = MS_IDLE;
                    n.scl_oe = 1'b0;
                end
            end
            MS_WAIT: begin
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                if (stop_p) begin
                    n.mst   = MS_START;
                    n.step  = 2'd0;
                    n.byten = 1'b0;
                    n.sh    = addr_byte(q.cmd);
                end
            end
            default: begin
                n.mst    = MS_IDLE;
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
            end
        endcase

        if (fin_ev) begin
            n.step = 2'd0;
            if (q.cmd[`I2CES_CMD_STOP]) begin
                n.mst = MS_STOP;
            end else begin
                n.mst    = MS_HOLD;
                n.scl_oe = 1'b1;
                n.sda_oe = 1'b0;
                set_v[`I2CES_BIT_MDNS] = 1'b1;
            end
        end
        if (arb_ev) begin
            n.mst    = MS_WAIT;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.result[`I2CES_RES_ERROR_TAG_FIELD_MSB:0] = `I2CES_ERROR_TAG_FIELD_ARB;
            set_v[`I2CES_BIT_ARB] = 1'b1;
        end
        if (ebus_m) begin
            // master recovery: abandon transfer and free both lines
            n.mst    = MS_IDLE;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
        end

        // ----------------------------------------------------------------
        // slave address listener
        // ----------------------------------------------------------------
        if (q.mst != MS_IDLE) begin
            n.slv_act = 1'b0;
        end else if (q.slv_act && (start_p || stop_p) && q.slv_cnt != 3'h0) begin
            // slave recovery: drop the half-received address
            n.slv_act = 1'b0;
            ebus_ev   = 1'b1;
        end else if (start_p) begin
            n.slv_act = 1'b1;
            n.slv_cnt = 3'h0;
        end else if (q.slv_act && scl_rise) begin
            n.slv_sh  = slv_byte;
            n.slv_cnt = q.slv_cnt + 3'h1;
            if (q.slv_cnt == `I2CES_LAST_SBIT) begin
                n.slv_act = 1'b0;
                if (slv_byte[7:1] == OWN_ADDR) n.slv_pend[slv_byte[0]] = 1'b1;
            end
        end
        // requests surface only once the unstopped done is acknowledged
        if (!q.raw[`I2CES_BIT_MDNS]) begin
            set_v[`I2CES_BIT_WTS] = q.slv_pend[0];
            set_v[`I2CES_BIT_RFS] = q.slv_pend[1];
            n.slv_pend = 2'b00;
        end

        ebus_ev = ebus_ev || ebus_m;
        if (ebus_ev) begin
            n.result[`I2CES_RES_ERROR_TAG_FIELD_MSB:0] = `I2CES_ERROR_TAG_FIELD_EBUS;
            set_v[`I2CES_BIT_EBUS] = 1'b1;
        end

        // set wins over a simultaneous clear
        n.raw = ((q.raw & ~clr_v) | set_v) & `I2CES_RAW_IMPL;
        n.irq = |(n.raw & n.mask);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= CORE_RST;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign avs_readdata             = q.rdata;
    assign avs_waitrequest          = q.waitreq;
    assign scl_out                  = 1'b0;
    assign sda_out                  = 1'b0;
    assign scl_oe                   = q.scl_oe;
    assign sda_oe                   = q.sda_oe;
    assign irq                      = q.irq;
    assign bus_error_flag           = q.raw[`I2CES_BIT_EBUS];
    assign master_done_no_stop_flag = q.raw[`I2CES_BIT_MDNS];
    assign arbitration_lost_flag    = q.raw[`I2CES_BIT_ARB];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_clr_ebus;
        wr_go && avs_address == `I2CES_OFS_CLR && avs_writedata[`I2CES_BIT_EBUS]
            && avs_byteenable[3] && !ebus_ev;
    endsequence

    sequence s_fin_nostop;
        fin_ev && !arb_ev && !ebus_m && !q.cmd[`I2CES_CMD_STOP];
    endsequence

    sequence s_raw_read;
        avs_read && q.waitreq && avs_address == `I2CES_OFS_RAW;
    endsequence

    ebus_set_a: assert property (ebus_ev |=> q.raw[`I2CES_BIT_EBUS])
        else $error("bus error flag not set");
    ebus_recov_a: assert property (ebus_m |=> q.mst == MS_IDLE && !q.scl_oe && !q.sda_oe)
        else $error("master not released after bus error");
    ebus_tag_a: assert property (ebus_ev |=> q.result[3:0] == `I2CES_ERROR_TAG_FIELD_EBUS)
        else $error("bus error tag missing");
    mdns_set_a: assert property (s_fin_nostop |=> q.raw[`I2CES_BIT_MDNS] && q.scl_oe
                                 ##1 q.mst == MS_HOLD)
        else $error("done without stop not flagged");
    no_stop_a: assert property (q.raw[`I2CES_BIT_MDNS] |-> q.mst != MS_STOP)
        else $error("stop sequence while done pending");
    cmd_refused_a: assert property (wr_go && avs_address == `I2CES_OFS_CMD
                                    && q.raw[`I2CES_BIT_MDNS] |=> q.mst != MS_START)
        else $error("command taken while done pending");
    scl_stretch_a: assert property (q.mst == MS_HOLD && q.raw[`I2CES_BIT_MDNS] |-> q.scl_oe)
        else $error("clock not stretched");
    slv_gate_a: assert property (q.raw[`I2CES_BIT_MDNS] |=> !$rose(q.raw[`I2CES_BIT_WTS])
                                 && !$rose(q.raw[`I2CES_BIT_RFS]))
        else $error("slave request raised before clear");
    ebus_clear_a: assert property (s_clr_ebus |=> !q.raw[`I2CES_BIT_EBUS])
        else $error("bus error flag not cleared");
    arb_flag_a: assert property (arb_ev && !ebus_m |=> q.raw[`I2CES_BIT_ARB]
                                 && q.mst == MS_WAIT)
        else $error("arbitration loss not flagged");
    arb_retry_a: assert property (q.mst == MS_WAIT && stop_p |=> q.mst == MS_START
                                  && q.sh == addr_byte(q.cmd))
        else $error("no retry after stop");
    rsvd_zero_a: assert property (s_raw_read |=> (q.rdata & ~`I2CES_RAW_IMPL) == 32'h0)
        else $error("reserved raw bits not zero");

endmodule // i2ces_core
`default_nettype wire

/* core/i2ces_sync.sv */
`timescale 1ns/1ns
`default_nettype none
`include "i2ces_regs.svh"

module i2ces_sync (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // pins from the bus
    input  wire logic [1:0] pin_async,
    // levels in the sys_clk domain
    output logic      [1:0] pin_sync
);
    import i2ces_pkg::*;

    i2ces_sync_reg_t q;
    i2ces_sync_reg_t n;

    always_comb begin
        n      = q;
        n.meta = pin_async;
        n.sync = q.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '{meta: `I2CES_PIN_IDLE, sync: `I2CES_PIN_IDLE};
        end else begin
            q <= n;
        end
    end

    assign pin_sync = q.sync;

endmodule // i2ces_sync
`default_nettype wire

/* pkg/i2ces_pkg.sv */
package i2ces_pkg;

    typedef enum logic [5:0] {
        MS_IDLE  = 6'b000001,
        MS_START = 6'b000010,
        MS_BIT   = 6'b000100,
        MS_STOP  = 6'b001000,
        MS_HOLD  = 6'b010000,
        MS_WAIT  = 6'b100000
    } i2ces_mst_t;

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] sync;
    } i2ces_sync_reg_t;

    typedef struct packed {
        logic scl_d;
        logic sda_d;
    } i2ces_det_reg_t;

    typedef struct packed {
        i2ces_mst_t  mst;
        logic [1:0]  step;
        logic [15:0] cnt;
        logic [3:0]  bitn;
        logic        byten;
        logic [7:0]  sh;
        logic [31:0] cmd;
        logic [31:0] mask;
        logic [31:0] raw;
        logic [15:0] result;
        logic        waitreq;
        logic [31:0] rdata;
        logic        irq;
        logic        scl_oe;
        logic        sda_oe;
        logic        slv_act;
        logic [2:0]  slv_cnt;
        logic [7:0]  slv_sh;
        logic [1:0]  slv_pend;
    } i2ces_core_reg_t;

endpackage

/* pkg/i2ces_regs.svh */
`ifndef I2CES_REGS_SVH
`define I2CES_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define I2CES_OFS_CMD       8'h00
`define I2CES_OFS_RESULT    8'h04
`define I2CES_OFS_MASK      8'h2c
`define I2CES_OFS_RAW       8'h30
`define I2CES_OFS_MSKD      8'h34
`define I2CES_OFS_CLR       8'h38

// ----------------------------------------------------------------
// event flag positions
// ----------------------------------------------------------------
`define I2CES_BIT_RFS       16
`define I2CES_BIT_WTS       18
`define I2CES_BIT_MTD       19
`define I2CES_BIT_ARB       24
`define I2CES_BIT_EBUS      25
`define I2CES_BIT_MDNS      28
`define I2CES_RAW_IMPL      32'h130d_0000
`define I2CES_RAW_RST       32'h0000_0000

// ----------------------------------------------------------------
// command and result fields
// ----------------------------------------------------------------
`define I2CES_CMD_RNW       7
`define I2CES_CMD_WD_MSB    15
`define I2CES_CMD_WD_LSB    8
`define I2CES_CMD_STOP      16
`define I2CES_CMD_IMPL      32'h0001_ffff
`define I2CES_RES_ERROR_TAG_FIELD_MSB 3
`define I2CES_RES_RX_MSB    15
`define I2CES_RES_RX_LSB    8
`define I2CES_ERROR_TAG_FIELD_OK      4'h0
`define I2CES_ERROR_TAG_FIELD_NACK    4'h1
`define I2CES_ERROR_TAG_FIELD_ARB     4'h2
`define I2CES_ERROR_TAG_FIELD_EBUS    4'h3

// ----------------------------------------------------------------
// timing and bus constants
// ----------------------------------------------------------------
`define I2CES_CLK_NS        20
`define I2CES_SCL_HALF_NS   80
`define I2CES_SCL_HALF_CYC  ((`I2CES_SCL_HALF_NS + `I2CES_CLK_NS - 1) / `I2CES_CLK_NS)
`define I2CES_ACK_BIT       4'h8
`define I2CES_LAST_SBIT     3'h7
`define I2CES_OWN_ADDR      7'h2a
`define I2CES_PIN_IDLE      2'h3

`endif

/* tb/i2ces_station.sv */
`timescale 1ns/1ns
`default_nettype none

module i2ces_station (
    // wire levels
    input  wire logic scl,
    input  wire logic sda,
    // pulls, high = line low
    output logic      scl_pull,
    output logic      sda_pull
);
    int   nfall    = 0;
    int   n_start  = 0;
    int   n_stop   = 0;
    logic ack_pull = 1'b0;
    logic drv_sda  = 1'b0;
    logic drv_scl  = 1'b0;

    assign scl_pull = drv_scl;
    assign sda_pull = drv_sda | ack_pull;

    // ----------------------------------------------------------------
    // listener: conditions and ack slot
    // ----------------------------------------------------------------
    always @(negedge sda) if (scl === 1'b1) begin
        n_start = n_start + 1;
        nfall   = 0;
    end
    always @(posedge sda) if (scl === 1'b1) n_stop = n_stop + 1;
    always @(negedge scl) begin
        nfall    = nfall + 1;
        ack_pull = (nfall % 9 == 0);
    end

    // ----------------------------------------------------------------
    // stray frames
    // ----------------------------------------------------------------
    // start, three clocks, stop: cut off inside an address
    task automatic frame_err();
        drv_sda = 1'b1;
        #80 drv_scl = 1'b1;
        repeat (2) begin
            #80 drv_scl = 1'b0;
            #80 drv_scl = 1'b1;
        end
        #80 drv_scl = 1'b0;
        #80 drv_sda = 1'b0;
    endtask

    // forces a 0 under the master's first address bit, then a stop
    task automatic jam();
        @(negedge sda iff scl === 1'b1);
        @(negedge scl);
        drv_sda = 1'b1;
        @(posedge scl);
        #400 drv_sda = 1'b0;
    endtask

    // start inside the master's first high half, then a stop
    task automatic stray();
        @(posedge scl);
        #30 drv_sda = 1'b1;
        #200 drv_sda = 1'b0;
    endtask
endmodule // i2ces_station

`default_nettype wire

/* tb/tb_i2c_error_and_done_status.sv */
`timescale 1ns/1ns
`default_nettype none
`include "i2ces_regs.svh"

module tb_i2c_error_and_done_status;
    logic        sys_clk         = 1'b0;
    logic        rst_n           = 1'b0;
    logic [7:0]  avs_address     = 8'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        scl_oe;
    logic        sda_oe;
    logic        irq;
    logic [2:0]  fl;
    logic        pt_scl;
    logic        pt_sda;
    wire         scl_w;
    wire         sda_w;
    int          n_mismatch      = 0;
    int          check_count     = 0;
    int          seed            = 42632;
    int          n0;
    logic [31:0] exp_raw;
    logic [31:0] q;
    logic [6:0]  adr;
    logic [7:0]  dat;

    assign scl_w = ~(scl_oe | pt_scl);
    assign sda_w = ~(sda_oe | pt_sda);
    always #10 sys_clk = ~sys_clk;

    i2ces_core i_i2ces_core (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
        .sda_oe(sda_oe), .irq(irq), .bus_error_flag(fl[1]),
        .master_done_no_stop_flag(fl[2]), .arbitration_lost_flag(fl[0]));
    i2ces_station i_i2ces_station (.scl(scl_w), .sda(sda_w), .scl_pull(pt_scl),
        .sda_pull(pt_sda));

    // ----------------------------------------------------------------
    // checks and bus cycles
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            final_report();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic chk_raw();
        bus(1'b0, `I2CES_OFS_RAW, 32'h0);
        chk(q, exp_raw);
        chk({29'h0, fl}, {29'h0, exp_raw[28], exp_raw[25], exp_raw[24]});
    endtask

    task automatic clear();
        bus(1'b1, `I2CES_OFS_CLR, exp_raw);
        exp_raw = 32'h0;
        chk_raw();
    endtask

    task automatic wait_raw(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, `I2CES_OFS_RAW, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 500);
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n   <= 1'b1;
        exp_raw = 32'h0;
        adr     = 7'($random(seed));
        dat     = 8'($random(seed));
        @(posedge sys_clk);
        chk_raw();
        bus(1'b1, `I2CES_OFS_RAW, 32'hffff_ffff);
        chk_raw();
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, `I2CES_OFS_MASK, 32'h1 << `I2CES_BIT_EBUS);
        i_i2ces_station.frame_err();
        @(posedge sys_clk);
        wait_raw(`I2CES_BIT_EBUS);
        exp_raw[`I2CES_BIT_EBUS] = 1'b1;
        chk_raw();
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, `I2CES_OFS_RESULT, 32'h0);
        chk({28'h0, q[3:0]}, {28'h0, `I2CES_ERROR_TAG_FIELD_EBUS});
        bus(1'b0, `I2CES_OFS_MSKD, 32'h0);
        chk(q, exp_raw);
        clear();
        chk({31'h0, irq}, 32'h0);
        adr[6] = 1'b0;
        bus(1'b1, `I2CES_OFS_CMD, {16'h0, dat, 1'b0, adr});
        wait_raw(`I2CES_BIT_MDNS);
        exp_raw[`I2CES_BIT_MDNS] = 1'b1;
        chk_raw();
        bus(1'b0, `I2CES_OFS_RESULT, 32'h0);
        chk({28'h0, q[3:0]}, {28'h0, `I2CES_ERROR_TAG_FIELD_OK});
        n0 = i_i2ces_station.n_start + i_i2ces_station.n_stop;
        bus(1'b1, `I2CES_OFS_CMD, {15'h0, 1'b1, dat, 1'b0, adr});
        repeat (200) @(posedge sys_clk);
        chk({31'h0, scl_oe}, 32'h1);
        chk(i_i2ces_station.n_start + i_i2ces_station.n_stop, n0);
        clear();
        repeat (20) @(posedge sys_clk);
        chk({31'h0, scl_oe}, 32'h0);
        bus(1'b1, `I2CES_OFS_CMD, {15'h0, 1'b1, dat, 1'b0, adr});
        wait_raw(`I2CES_BIT_MTD);
        exp_raw[`I2CES_BIT_MTD] = 1'b1;
        chk_raw();
        clear();
        adr[6] = 1'b1;
        fork
            i_i2ces_station.jam();
        join_none
        bus(1'b1, `I2CES_OFS_CMD, {16'h0, dat, 1'b0, adr});
        wait_raw(`I2CES_BIT_MDNS);
        exp_raw[`I2CES_BIT_ARB]  = 1'b1;
        exp_raw[`I2CES_BIT_MDNS] = 1'b1;
        chk_raw();
        chk({31'h0, irq}, 32'h0);
        clear();
        fork
            i_i2ces_station.stray();
        join_none
        bus(1'b1, `I2CES_OFS_CMD, {15'h0, 1'b1, dat, 1'b0, adr});
        wait_raw(`I2CES_BIT_EBUS);
        exp_raw[`I2CES_BIT_EBUS] = 1'b1;
        chk_raw();
        chk({30'h0, scl_oe, sda_oe}, 32'h0);
        bus(1'b0, `I2CES_OFS_RESULT, 32'h0);
        chk({28'h0, q[3:0]}, {28'h0, `I2CES_ERROR_TAG_FIELD_EBUS});
        clear();
        final_report();
    end

    // hang guard
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        final_report();
    end
endmodule // tb_i2c_error_and_done_status

`default_nettype wire
